// >>> logic/bridge_cfg_pkg.sv
// Constants and carriers for the bridge I/O window and control registers.
// Assumes configuration accesses arrive already decoded to this header region.
package bridge_cfg_pkg;
   // Register byte offsets in the type-1 header
   localparam logic [7:0] IO_BASE_HIGH_OFS = 8'h30;
   localparam logic [7:0] IO_LIMIT_HIGH_OFS = 8'h32;
   localparam logic [7:0] CAP_PTR_OFS = 8'h34;
   localparam logic [7:0] INT_LINE_OFS = 8'h3c;
   localparam logic [7:0] INT_PIN_OFS = 8'h3d;
   localparam logic [7:0] BRIDGE_CTRL_OFS = 8'h3e;
   localparam int DWORD_LSB = 2;
   // Reset and fixed values
   localparam logic [15:0] IO_WINDOW_RST = 16'h0000;
   localparam logic [7:0] CAP_PTR_VALUE = 8'h40;
   localparam logic [7:0] INT_LINE_RST = 8'hff;
   localparam logic [7:0] INT_PIN_VALUE = 8'h00;
   // Bridge control bit positions (within the 16-bit register)
   localparam int BC_MSG_EN_BIT = 11;
   localparam int BC_FLAG_BIT = 10;
   localparam int BC_PERIOD_BIT = 9;
   // Byte lane of the dword at 3Ch holding bridge control bits 15:8
   localparam int BC_HIGH_LANE = 3;
   // Discard timer periods in PCI clocks
   localparam int DT_LONG_CYCLES = 32768;
   localparam int DT_SHORT_CYCLES = 1024;
   localparam int DT_CNT_W = 16;
   localparam logic [DT_CNT_W-1:0] DT_CNT_ZERO = 16'h0000;

   // Configuration request carrier
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [3:0] be;
      logic [31:0] wdata;
   } cfg_req_t;

   // Configuration read answer
   typedef struct packed {
      logic valid;
      logic [31:0] data;
   } cfg_rsp_t;

   // Error message request toward the primary interface
   typedef struct packed {
      logic valid;
      logic fatal;
   } err_msg_t;

   // Discard timer states, Gray coded
   typedef enum logic [1:0] {
      DT_IDLE = 2'b00,
      DT_RUN = 2'b01
   } dt_state_t;
endpackage : bridge_cfg_pkg

// >>> logic/bridge_io_window_and_control_regs.sv
// I/O window upper halves, capability pointer, interrupt bytes and upper
// bridge control bits, with the secondary discard timer and its error path.
// Assumes one core clock that also times the secondary PCI clock count.
// Notes on behaviour
// R01: I/O base high is 16-bit RW, resets zero, low address bits zero.
// R02: I/O limit high is 16-bit RW, resets zero, low address bits ones.
// R03: Forward I/O downstream only when address lies within base and limit.
// R04: Capability pointer reads fixed 40h, read-only.
// R05: Interrupt line is scratch RW, resets FFh, affects nothing.
// R06: Interrupt pin reads 00h, read-only.
// R07: Secondary interrupts are passed through to the primary side.
// R08: Bridge control bits 15:12 always read zero.
// R09: Conventional mode, enable set, discard expiry sends error message.
// R10: Fatal severity choosable only with advanced error reporting, else nonfatal.
// R11: Enable clear still sends message if reporting supported and mask clear.
// R12: Discard timer counts 2^15 or 2^10 clocks, drops unrepeated transaction.
// R13: Discard expiry sets a read-to-clear status flag.
// R14: Writes to pointer, pin and reserved bits are ignored.
`timescale 1ns/1ps
`default_nettype none
module bridge_io_window_and_control_regs
   import bridge_cfg_pkg::*;
#(
   parameter int DT_LONG = bridge_cfg_pkg::DT_LONG_CYCLES,
   parameter int DT_SHORT = bridge_cfg_pkg::DT_SHORT_CYCLES
)
(
   input wire logic CLK,
   input wire logic SYS_RST,
   input wire logic CE,
   input wire bridge_cfg_pkg::cfg_req_t CFG_REQ,
   output bridge_cfg_pkg::cfg_rsp_t CFG_RSP,
   input wire logic IO_REQ_VALID,
   input wire logic [31:0] IO_REQ_ADDR,
   output logic IO_FWD_VALID,
   output logic IO_FWD_HIT,
   input wire logic [3:0] SEC_INTX,
   output logic [3:0] PRI_INTX,
   input wire logic CONV_PCI_MODE,
   input wire logic AER_SUPPORTED,
   input wire logic AER_SEV_FATAL,
   input wire logic AER_DT_MASK,
   input wire logic DT_START,
   input wire logic DT_REPEAT,
   output logic DT_DISCARD,
   output bridge_cfg_pkg::err_msg_t ERR_MSG
);
   import bridge_cfg_pkg::*;

   // Merge enabled bytes of a write into a 16-bit field
   function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [15:0] wd,
                                            input logic [1:0] be);
      logic [15:0] res;
      res = old;
      if (be[0])
      begin
         res[7:0] = wd[7:0];
      end
      if (be[1])
      begin
         res[15:8] = wd[15:8];
      end
      return res;
   endfunction : merge16

   // Window test on the upper 16 address bits
   function automatic logic in_window(input logic [31:0] addr,
                                      input logic [15:0] base,
                                      input logic [15:0] limit);
      return (addr[31:16] >= base) && (addr[31:16] <= limit);
   endfunction : in_window

   // Dword index of a byte offset
   function automatic logic [5:0] dw(input logic [7:0] ofs);
      return ofs[7:DWORD_LSB];
   endfunction : dw

   localparam logic [DT_CNT_W-1:0] DT_LONG_LOAD = DT_CNT_W'(DT_LONG - 1);
   localparam logic [DT_CNT_W-1:0] DT_SHORT_LOAD = DT_CNT_W'(DT_SHORT - 1);

   logic [15:0] io_window_base_high_reg, io_window_base_high_next;
   logic [15:0] io_window_limit_high_reg, io_window_limit_high_next;
   logic [7:0] interrupt_route_scratch_reg, interrupt_route_scratch_next;
   logic discard_timeout_msg_en_reg, discard_timeout_msg_en_next;
   logic discard_timeout_flag_reg, discard_timeout_flag_next;
   logic secondary_discard_period_sel_reg, secondary_discard_period_sel_next;
   dt_state_t dt_state_reg, dt_state_next;
   logic [DT_CNT_W-1:0] dt_cnt_reg, dt_cnt_next;
   cfg_rsp_t rsp_reg, rsp_next;
   err_msg_t msg_reg, msg_next;
   logic discard_reg, discard_next;
   logic fwd_valid_reg, fwd_valid_next;
   logic fwd_hit_reg, fwd_hit_next;
   logic [3:0] intx_reg, intx_next;
   logic [15:0] bridge_control;
   logic [5:0] req_dw;
   logic expire;

   assign req_dw = CFG_REQ.addr[7:DWORD_LSB];
   assign expire = (dt_state_reg == DT_RUN) && !DT_REPEAT && (dt_cnt_reg == DT_CNT_ZERO);

   // Bridge control image: 15:12 and 8:0 read zero
   always_comb
   begin
      bridge_control = 16'h0000; // R08
      bridge_control[BC_MSG_EN_BIT] = discard_timeout_msg_en_reg;
      bridge_control[BC_FLAG_BIT] = discard_timeout_flag_reg;
      bridge_control[BC_PERIOD_BIT] = secondary_discard_period_sel_reg;
   end

   // Register writes and read-to-clear flag
   always_comb
   begin
      io_window_base_high_next = io_window_base_high_reg;
      io_window_limit_high_next = io_window_limit_high_reg;
      interrupt_route_scratch_next = interrupt_route_scratch_reg;
      discard_timeout_msg_en_next = discard_timeout_msg_en_reg;
      secondary_discard_period_sel_next = secondary_discard_period_sel_reg;
      discard_timeout_flag_next = discard_timeout_flag_reg;
      if (CFG_REQ.wr && req_dw == dw(IO_BASE_HIGH_OFS))
      begin
         io_window_base_high_next = merge16(io_window_base_high_reg,
                                            CFG_REQ.wdata[15:0], CFG_REQ.be[1:0]); // R01
         io_window_limit_high_next = merge16(io_window_limit_high_reg,
                                             CFG_REQ.wdata[31:16], CFG_REQ.be[3:2]); // R02
      end
      else if (CFG_REQ.wr && req_dw == dw(INT_LINE_OFS))
      begin
         // Pin byte (lane 1) and reserved bits are never written
         if (CFG_REQ.be[0])
         begin
            interrupt_route_scratch_next = CFG_REQ.wdata[7:0]; // R05
         end
         if (CFG_REQ.be[BC_HIGH_LANE])
         begin
            discard_timeout_msg_en_next = CFG_REQ.wdata[16 + BC_MSG_EN_BIT]; // R14
            secondary_discard_period_sel_next = CFG_REQ.wdata[16 + BC_PERIOD_BIT];
         end
      end
      // Read of the upper control byte clears the flag
      if (CFG_REQ.rd && req_dw == dw(BRIDGE_CTRL_OFS) && CFG_REQ.be[BC_HIGH_LANE])
      begin
         discard_timeout_flag_next = 1'b0; // R13
      end
      // A new expiry wins over the clear
      if (expire)
      begin
         discard_timeout_flag_next = 1'b1; // R13
      end
   end

   // Register state
   always_ff @(posedge CLK or posedge SYS_RST)
   begin
      if (SYS_RST)
      begin
         io_window_base_high_reg <= IO_WINDOW_RST;
         io_window_limit_high_reg <= IO_WINDOW_RST;
         interrupt_route_scratch_reg <= INT_LINE_RST;
         discard_timeout_msg_en_reg <= 1'b0;
         discard_timeout_flag_reg <= 1'b0;
         secondary_discard_period_sel_reg <= 1'b0;
      end
      else if (CE)
      begin
         io_window_base_high_reg <= io_window_base_high_next;
         io_window_limit_high_reg <= io_window_limit_high_next;
         interrupt_route_scratch_reg <= interrupt_route_scratch_next;
         discard_timeout_msg_en_reg <= discard_timeout_msg_en_next;
         discard_timeout_flag_reg <= discard_timeout_flag_next;
         secondary_discard_period_sel_reg <= secondary_discard_period_sel_next;
      end
   end

   // Discard timer: armed when the completion reaches the queue head
   always_comb
   begin
      dt_state_next = dt_state_reg;
      dt_cnt_next = dt_cnt_reg;
      case (dt_state_reg)
         DT_IDLE:
         begin
            if (DT_START)
            begin
               dt_state_next = DT_RUN;
               dt_cnt_next = secondary_discard_period_sel_reg ? DT_SHORT_LOAD
                                                              : DT_LONG_LOAD; // R12
            end
         end
         DT_RUN:
         begin
            if (DT_REPEAT || expire)
            begin
               dt_state_next = DT_IDLE; // R12
            end
            else
            begin
               dt_cnt_next = dt_cnt_reg - 16'h0001;
            end
         end
         default:
         begin
            dt_state_next = DT_IDLE;
         end
      endcase
   end

   // Discard timer state
   always_ff @(posedge CLK or posedge SYS_RST)
   begin
      if (SYS_RST)
      begin
         dt_state_reg <= DT_IDLE;
         dt_cnt_reg <= DT_CNT_ZERO;
      end
      else if (CE)
      begin
         dt_state_reg <= dt_state_next;
         dt_cnt_reg <= dt_cnt_next;
      end
   end

   // Read data, forwarding decision, pass-through and error message
   always_comb
   begin
      rsp_next.valid = CFG_REQ.rd;
      rsp_next.data = 32'h0000_0000;
      if (CFG_REQ.rd && req_dw == dw(IO_BASE_HIGH_OFS))
      begin
         rsp_next.data = {io_window_limit_high_reg, io_window_base_high_reg};
      end
      else if (CFG_REQ.rd && req_dw == dw(CAP_PTR_OFS))
      begin
         rsp_next.data = {24'h000000, CAP_PTR_VALUE}; // R04
      end
      else if (CFG_REQ.rd && req_dw == dw(INT_LINE_OFS))
      begin
         rsp_next.data = {bridge_control, INT_PIN_VALUE, interrupt_route_scratch_reg}; // R06
      end
      fwd_valid_next = IO_REQ_VALID;
      fwd_hit_next = IO_REQ_VALID && in_window(IO_REQ_ADDR, io_window_base_high_reg,
                                               io_window_limit_high_reg); // R03
      intx_next = SEC_INTX; // R07
      discard_next = expire; // R12
      msg_next.valid = expire && CONV_PCI_MODE &&
                       (discard_timeout_msg_en_reg || (AER_SUPPORTED && !AER_DT_MASK)); // R09 R11
      msg_next.fatal = msg_next.valid && AER_SUPPORTED && AER_SEV_FATAL; // R10
   end

   // Output registers
   always_ff @(posedge CLK or posedge SYS_RST)
   begin
      if (SYS_RST)
      begin
         rsp_reg <= '0;
         fwd_valid_reg <= 1'b0;
         fwd_hit_reg <= 1'b0;
         intx_reg <= 4'h0;
         discard_reg <= 1'b0;
         msg_reg <= '0;
      end
      else if (CE)
      begin
         rsp_reg <= rsp_next;
         fwd_valid_reg <= fwd_valid_next;
         fwd_hit_reg <= fwd_hit_next;
         intx_reg <= intx_next;
         discard_reg <= discard_next;
         msg_reg <= msg_next;
      end
   end

   assign CFG_RSP = rsp_reg;
   assign IO_FWD_VALID = fwd_valid_reg;
   assign IO_FWD_HIT = fwd_hit_reg;
   assign PRI_INTX = intx_reg;
   assign DT_DISCARD = discard_reg;
   assign ERR_MSG = msg_reg;
endmodule : bridge_io_window_and_control_regs
`default_nettype wire

// >>> sim/bridge_regs_props.sv
// Port-level checks on the window and control register block.
// Assumes a bind onto the block and its single core clock.
`timescale 1ns/1ps
`default_nettype none
module bridge_regs_props
   import bridge_cfg_pkg::*;
(
   input wire logic CLK,
   input wire logic SYS_RST,
   input wire logic CE,
   input wire bridge_cfg_pkg::cfg_req_t CFG_REQ,
   input wire bridge_cfg_pkg::cfg_rsp_t CFG_RSP,
   input wire logic IO_REQ_VALID,
   input wire logic IO_FWD_VALID,
   input wire logic IO_FWD_HIT,
   input wire logic [3:0] SEC_INTX,
   input wire logic [3:0] PRI_INTX,
   input wire logic CONV_PCI_MODE,
   input wire logic AER_SUPPORTED,
   input wire logic DT_REPEAT,
   input wire logic DT_DISCARD,
   input wire bridge_cfg_pkg::err_msg_t ERR_MSG
);
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (SYS_RST);
   // Config answers
   rd_answer_a: assert property (CE && CFG_REQ.rd |=> CFG_RSP.valid)
      else $error("read not answered");
   rsp_cause_a: assert property (CFG_RSP.valid |-> $past(CFG_REQ.rd && CE))
      else $error("answer without read");
   cap_fixed_a: assert property (CE && CFG_REQ.rd && CFG_REQ.addr[7:2] == 6'h0d
      |=> CFG_RSP.data == {24'h0, CAP_PTR_VALUE}) else $error("pointer wrong");
   ctl_zero_a: assert property (CE && CFG_REQ.rd && CFG_REQ.addr[7:2] == 6'h0f
      |=> CFG_RSP.data[31:28] == 4'h0 && CFG_RSP.data[15:8] == INT_PIN_VALUE)
      else $error("fixed bits wrong");
   // Forwarding and interrupts
   fwd_next_a: assert property (CE && IO_REQ_VALID |=> IO_FWD_VALID)
      else $error("forward answer late");
   hit_valid_a: assert property (IO_FWD_HIT |-> IO_FWD_VALID)
      else $error("hit without valid");
   intx_pass_a: assert property (CE |=> PRI_INTX == $past(SEC_INTX))
      else $error("interrupt not passed");
   // Discard path
   err_cause_a: assert property (ERR_MSG.valid |-> DT_DISCARD && $past(CONV_PCI_MODE))
      else $error("message without discard");
   fatal_aer_a: assert property (ERR_MSG.fatal |-> ERR_MSG.valid && $past(AER_SUPPORTED))
      else $error("fatal without reporting");
   discard_pulse_a: assert property (DT_DISCARD |-> !$past(DT_REPEAT) ##1 !DT_DISCARD)
      else $error("discard pulse wrong");
endmodule : bridge_regs_props
`default_nettype wire

// >>> sim/cfg_host_model.sv
// Host configuration software issuing single config requests.
// Assumes requests change at the falling edge of the core clock.
`timescale 1ns/1ps
`default_nettype none
module cfg_host_model
   import bridge_cfg_pkg::*;
(
   input wire logic CLK,
   input wire bridge_cfg_pkg::cfg_rsp_t CFG_RSP,
   output bridge_cfg_pkg::cfg_req_t CFG_REQ
);
   initial CFG_REQ = '0;
   // One request; idle bus shows inverted leftovers
   task automatic xfer(input logic w, input logic [7:0] a, input logic [3:0] be,
      input logic [31:0] d, output logic [31:0] q);
      @(negedge CLK);
      CFG_REQ = '{wr: w, rd: !w, addr: a, be: be, wdata: d};
      @(negedge CLK);
      q = CFG_RSP.data;
      CFG_REQ = '{wr: 1'b0, rd: 1'b0, addr: ~a, be: ~be, wdata: ~d};
   endtask : xfer
endmodule : cfg_host_model
`default_nettype wire

// >>> sim/bridge_io_window_and_control_regs_tb.sv
// Self-checking bench for the window and control register block.
// Assumes the host model and the checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module bridge_io_window_and_control_regs_tb;
   import bridge_cfg_pkg::*;
   localparam int N = 8;
   localparam logic [75:0] ROWS [8] = '{
      {8'h30, 4'h0, 32'hffff_ffff, 32'h0000_0000},
      {8'h3c, 4'h0, 32'hffff_ffff, 32'h0000_00ff},
      {8'h30, 4'hf, 32'h1234_0010, 32'h1234_0010},
      {8'h30, 4'h5, 32'haabb_ccdd, 32'h12bb_00dd},
      {8'h34, 4'hf, 32'hffff_ffff, 32'h0000_0040},
      {8'h3c, 4'hf, 32'hffff_ffa5, 32'h0a00_00a5},
      {8'h38, 4'hf, 32'hdead_beef, 32'h0000_0000},
      {8'h3c, 4'h9, 32'h0200_0033, 32'h0200_0033}};
   localparam logic [31:0] IO_ADDRS [4] = '{32'h00dd_0000, 32'h00dc_ffff,
      32'h12bb_ffff, 32'h12bc_0000};
   localparam logic [3:0] IO_HITS = 4'b0101;
   localparam logic [7:0] DT_ROWS [6] = '{8'hc6, 8'hd4, 8'hc8, 8'hf7, 8'ha6, 8'h64};
   logic clk, rst, ce, io_v, fwd_v, fwd_h, conv, aer, sev, mask, dt_s, dt_r, dt_d;
   logic [31:0] io_a, q;
   logic [3:0] intx, pri;
   cfg_req_t req;
   cfg_rsp_t rsp;
   err_msg_t err;
   int fails = 0, samples_checked = 0, cycles = 0;
   bridge_io_window_and_control_regs #(.DT_LONG(40), .DT_SHORT(N)) dut (
      .CLK(clk), .SYS_RST(rst), .CE(ce), .CFG_REQ(req), .CFG_RSP(rsp),
      .IO_REQ_VALID(io_v), .IO_REQ_ADDR(io_a), .IO_FWD_VALID(fwd_v), .IO_FWD_HIT(fwd_h),
      .SEC_INTX(intx), .PRI_INTX(pri), .CONV_PCI_MODE(conv), .AER_SUPPORTED(aer),
      .AER_SEV_FATAL(sev), .AER_DT_MASK(mask), .DT_START(dt_s), .DT_REPEAT(dt_r),
      .DT_DISCARD(dt_d), .ERR_MSG(err));
   cfg_host_model host (.CLK(clk), .CFG_RSP(rsp), .CFG_REQ(req));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         fails++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic summarize();
      $display("checked %0d failed %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : summarize
   // Arm the timer, optionally repeat in the expiry cycle
   task automatic dt_run(input logic [7:0] c);
      @(negedge clk);
      {conv, aer, sev, mask} = c[7:4];
      dt_s = 1'b1;
      @(negedge clk);
      dt_s = 1'b0;
      repeat (N - 1) @(negedge clk);
      chk(dt_d, 0);
      dt_r = c[3];
      @(negedge clk);
      dt_r = 1'b0;
      chk({dt_d, err.valid, err.fatal}, c[2:0]);
   endtask : dt_run
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // Hang guard
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 1000)
      begin
         fails++;
         summarize();
      end
   end
   initial
   begin
      rst = 1'b1;
      ce = 1'b1;
      {io_v, conv, aer, sev, mask, dt_s, dt_r} = '0;
      io_a = '0;
      intx = '0;
      repeat (4) @(negedge clk);
      rst = 1'b0;
      foreach (ROWS[i])
      begin
         host.xfer(1'b1, ROWS[i][75:68], ROWS[i][67:64], ROWS[i][63:32], q);
         host.xfer(1'b0, ROWS[i][75:68], 4'hf, 32'h0, q);
         chk(q, ROWS[i][31:0]);
      end
      $display("register rows done");
      // Back-to-back window edges with interrupt levels alongside
      for (int i = 0; i < 5; i++)
      begin
         @(negedge clk);
         if (i > 0)
            chk({fwd_v, fwd_h, pri}, {1'b1, IO_HITS[i-1], 4'(i + 4)});
         io_v = (i < 4);
         io_a = IO_ADDRS[i%4];
         intx = 4'(i + 5);
      end
      $display("window done");
      foreach (DT_ROWS[i])
      begin
         if (i == 3)
            host.xfer(1'b1, 8'h3c, 4'h8, 32'h0a00_0000, q);
         dt_run(DT_ROWS[i]);
      end
      host.xfer(1'b0, 8'h3c, 4'hf, 32'h0, q);
      chk(q, 32'h0e00_0033);
      host.xfer(1'b0, 8'h3c, 4'hf, 32'h0, q);
      chk(q, 32'h0a00_0033);
      $display("discard timer done");
      // Mid-run reset returns registers and outputs to their reset values
      @(negedge clk);
      rst = 1'b1;
      @(negedge clk);
      chk({rsp.valid, fwd_v, fwd_h, pri, dt_d, err}, 0);
      chk(rsp.data, 0);
      rst = 1'b0;
      host.xfer(1'b0, 8'h30, 4'hf, 32'h0, q);
      chk(q, 32'h0000_0000);
      host.xfer(1'b0, 8'h3c, 4'hf, 32'h0, q);
      chk(q, 32'h0000_00ff);
      $display("reset done");
      // Clock enable low freezes the registers against a write
      @(negedge clk);
      ce = 1'b0;
      host.xfer(1'b1, 8'h30, 4'hf, 32'h5555_aaaa, q);
      ce = 1'b1;
      host.xfer(1'b0, 8'h30, 4'hf, 32'h0, q);
      chk(q, 32'h0000_0000);
      $display("clock enable done");
      summarize();
   end
endmodule : bridge_io_window_and_control_regs_tb
bind bridge_io_window_and_control_regs bridge_regs_props props (.CLK(CLK), .SYS_RST(SYS_RST),
   .CE(CE), .CFG_REQ(CFG_REQ), .CFG_RSP(CFG_RSP), .IO_REQ_VALID(IO_REQ_VALID),
   .IO_FWD_VALID(IO_FWD_VALID), .IO_FWD_HIT(IO_FWD_HIT), .SEC_INTX(SEC_INTX),
   .PRI_INTX(PRI_INTX), .CONV_PCI_MODE(CONV_PCI_MODE), .AER_SUPPORTED(AER_SUPPORTED),
   .DT_REPEAT(DT_REPEAT), .DT_DISCARD(DT_DISCARD), .ERR_MSG(ERR_MSG));
`default_nettype wire
